/* opdec_pkg.sv */
/*
 * Shared constants and types of the opcode field decoder: field positions
 * of the 16-bit instruction word, register offsets, forms and step modes.
 * Assumes a single core clock domain.
 */
`default_nettype none

package opdec_pkg;

    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int unsigned WORD_W = 16;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned BANK_W = 4;
    localparam int unsigned TPTR_W = 21;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int unsigned POS_D     = 9;
    localparam int unsigned POS_A     = 8;
    localparam int unsigned POS_B     = 9;
    localparam int unsigned POS_S_CAL = 8;
    localparam int unsigned POS_S_RET = 0;
    localparam int unsigned POS_PTR   = 4;
    localparam int unsigned POS_TAG   = 12;
    localparam logic [3:0]  SECOND_TAG = 4'hf;
    localparam logic [7:0]  ACCESS_SPLIT = 8'h80;
    localparam logic [3:0]  ACC_LO_BANK = 4'h0;
    localparam logic [3:0]  ACC_HI_BANK = 4'hf;

    // ----------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] REG_BANK  = 8'h00;
    localparam logic [7:0] REG_WACC  = 8'h04;
    localparam logic [7:0] REG_FLAGS = 8'h08;
    localparam logic [7:0] REG_TPTR  = 8'h0c;
    localparam logic [7:0] REG_TLAT  = 8'h10;
    localparam logic [7:0] REG_IWORD = 8'h14;
    localparam logic [7:0] REG_DSTAT = 8'h18;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [3:0] {
        form_byte  = 4'h0, form_bit   = 4'h1, form_move = 4'h2,
        form_lit8  = 4'h3, form_ptrld = 4'h4, form_far  = 4'h5,
        form_call  = 4'h6, form_rel11 = 4'h7, form_rel8 = 4'h8,
        form_table = 4'h9, form_ret   = 4'ha, form_idx  = 4'hb,
        form_none  = 4'hf
    } form_e;

    typedef enum logic [1:0] {
        step_hold = 2'b00, step_post_inc = 2'b01,
        step_post_dec = 2'b10, step_pre_inc = 2'b11
    } step_e;

    typedef struct packed {
        logic negative;
        logic signed_wrap_flag;
        logic zero;
        logic half_carry_flag;
        logic carry;
    } status_s;

    typedef struct packed {
        logic        nop;
        form_e       form;
        logic [11:0] ram_addr;
        logic        dest_file;
        logic [2:0]  bit_index;
        logic [7:0]  bit_mask;
        logic [1:0]  ptr_sel;
        logic [11:0] src_addr;
        logic [11:0] dst_addr;
        logic [7:0]  lit8;
        logic [11:0] lit12;
        logic [19:0] lit20;
        logic [20:0] rel_disp;
        logic [20:0] abs_target;
        logic        fast;
        step_e       step;
        logic [6:0]  off_src;
        logic [6:0]  off_dst;
    } decode_s;

endpackage : opdec_pkg

`default_nettype wire

/* fast_shadow_bank.sv */
/*
 * Shadow copies of accumulator, status and bank select for fast
 * call and return. Assumes save is a one-cycle strobe on core_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module fast_shadow_bank
    import opdec_pkg::*;
(
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              resetn,
    // Save port
    input  wire logic              save,
    input  wire logic [7:0]        wacc_d,
    input  wire opdec_pkg::status_s flags_d,
    input  wire logic [BANK_W-1:0] bank_d,
    // Held copies
    output logic [7:0]             wacc_q,
    output opdec_pkg::status_s     flags_q,
    output logic [BANK_W-1:0]      bank_q
);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wacc_q  <= '0;
            flags_q <= '0;
            bank_q  <= '0;
        end else if (save) begin
            wacc_q  <= wacc_d;
            flags_q <= flags_d;
            bank_q  <= bank_d;
        end
    end

endmodule : fast_shadow_bank

`default_nettype wire

/* opcode_field_decoder.sv */
/*
 * Operand field decoder of an 8-bit core with 16-bit instruction words.
 * Holds the fetched words, pairs two-word forms, and extracts all operand
 * fields. Also keeps accumulator, bank select, status flags, table pointer
 * and table latch. Assumes the fetch unit classifies each first word into
 * a form and that all inputs come from core_clk logic.
 */
// Our own choices: the register offsets and the address-and-strobe port.
// How it works
// - With the access bit clear the address lands in access RAM and the bank select is ignored.
// - With the access bit set the bank select supplies the upper address bits.
// - Destination bit clear writes the accumulator, set writes the file register.
// - Bit forms take a three-bit index naming bit 0 to 7 of the file byte.
// - The file field is an 8-bit address, or a two-bit pointer selector for pointer loads.
// - Moves carry full 12-bit source and destination addresses with no banking.
// - Table forms step the table pointer: hold, post-increment, post-decrement, pre-increment.
// - The fast bit of calls and returns saves to or restores from the shadow copies.
// - Table access uses a 21-bit pointer and an 8-bit latch for each byte.
// - Literals come out as 8, 12 or 20 bits by form.
// - Branch fields are signed displacements for relative forms, absolute for far ones.
// - Indexed forms add separate 7-bit source and destination offsets to the pointer.
// - Don't-care bits never change what is decoded.
// - Five status flags are kept and updated per executed instruction.
// - A second word has its top nibble all ones and alone executes as a no-operation.
`timescale 1ns/1ps
`default_nettype none

module opcode_field_decoder
    import opdec_pkg::*;
(
    // Clock and reset
    input  wire logic               core_clk,
    input  wire logic               resetn,
    // Fetch
    input  wire logic               fetch_valid,
    input  wire logic [WORD_W-1:0]  fetch_word,
    input  wire opdec_pkg::form_e   fetch_form,
    // Decoded fields
    output opdec_pkg::decode_s      dec,
    output logic                    dec_valid,
    output logic                    await_second,
    // Datapath
    input  wire logic               result_valid,
    input  wire logic [7:0]         result_data,
    output logic                    file_we,
    input  wire opdec_pkg::status_s flag_we,
    input  wire opdec_pkg::status_s flag_in,
    input  wire logic               call_strobe,
    input  wire logic               ret_strobe,
    input  wire logic [ADDR_W-1:0]  idx_base,
    output logic [ADDR_W-1:0]       eff_src,
    output logic [ADDR_W-1:0]       eff_dst,
    // Table access
    input  wire logic               tbl_strobe,
    input  wire logic               tbl_data_valid,
    input  wire logic [7:0]         tbl_data,
    output logic [TPTR_W-1:0]       tbl_addr,
    // Core state
    output logic [7:0]              working_accumulator,
    output logic [BANK_W-1:0]       bank_select_reg,
    output opdec_pkg::status_s      status_flags,
    output logic [TPTR_W-1:0]       program_table_pointer,
    output logic [7:0]              table_read_latch,
    // Register port
    input  wire logic [7:0]         reg_addr,
    input  wire logic [31:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [31:0]             reg_rdata
);
    import opdec_pkg::*;

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function automatic logic [11:0] data_addr(
        input logic a, input logic [7:0] f, input logic [3:0] bank);
        return a ? {bank, f} : {((f < ACCESS_SPLIT) ? ACC_LO_BANK : ACC_HI_BANK), f};
    endfunction : data_addr
    function automatic logic [20:0] sext11(input logic [10:0] v);
        return {{10{v[10]}}, v};
    endfunction : sext11
    function automatic logic two_word(input form_e fm);
        return (fm == form_move) || (fm == form_ptrld) || (fm == form_far) ||
               (fm == form_call) || (fm == form_idx);
    endfunction : two_word
    function automatic logic [20:0] ptr_used(input logic [20:0] p, input step_e s);
        return (s == step_pre_inc) ? p + 21'h000001 : p;
    endfunction : ptr_used
    function automatic logic [20:0] ptr_next(input logic [20:0] p, input step_e s);
        case (s)
            step_post_inc, step_pre_inc: return p + 21'h000001;
            step_post_dec: return p - 21'h000001;
            default: return p;
        endcase
    endfunction : ptr_next

    // ----------------------------------------
    // Instruction holding and pairing
    // ----------------------------------------
    typedef enum logic [0:0] {st_first = 1'b0, st_second = 1'b1} fetch_state_e;

    fetch_state_e      state_q;
    logic [WORD_W-1:0] word0_q;
    logic [WORD_W-1:0] word1_q;
    form_e             form_q;
    logic              full_q;
    logic              lone_tag;
    logic              pair_tag;
    assign lone_tag = fetch_word[POS_TAG +: 4] == SECOND_TAG;
    assign pair_tag = lone_tag;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= st_first;
            word0_q <= '0;
            word1_q <= '0;
            form_q  <= form_none;
            full_q  <= 1'b0;
        end else if (fetch_valid) begin
            case (state_q)
                st_first: begin
                    word0_q <= fetch_word;
                    word1_q <= '0;
                    form_q  <= lone_tag ? form_none : fetch_form;
                    full_q  <= lone_tag || !two_word(fetch_form);
                    if (!lone_tag && two_word(fetch_form))
                        state_q <= st_second;
                end
                st_second: begin
                    word1_q <= fetch_word;
                    full_q  <= 1'b1;
                    state_q <= st_first;
                    if (!pair_tag)
                        form_q <= form_none;
                end
                default: state_q <= st_first;
            endcase
        end
    end

    assign dec_valid    = full_q;
    assign await_second = state_q == st_second;

    // ----------------------------------------
    // Field extraction
    // ----------------------------------------
    logic [BANK_W-1:0] bank_q;
    always_comb begin
        dec      = '0;
        dec.form = form_q;
        dec.nop  = form_q == form_none;
        dec.step = step_hold;
        case (form_q)
            form_byte: begin
                dec.ram_addr  = data_addr(word0_q[POS_A], word0_q[7:0],
                                          bank_q);
                dec.dest_file = word0_q[POS_D];
            end
            form_bit: begin
                dec.ram_addr  = data_addr(word0_q[POS_A], word0_q[7:0], bank_q);
                dec.bit_index = word0_q[POS_B +: 3];
                dec.bit_mask  = 8'h01 << word0_q[POS_B +: 3];
            end
            form_move: begin
                dec.src_addr = word0_q[11:0];
                dec.dst_addr = word1_q[11:0];
            end
            form_lit8: dec.lit8 = word0_q[7:0];
            form_ptrld: begin
                dec.ptr_sel = word0_q[POS_PTR +: 2];
                dec.lit12   = {word0_q[3:0], word1_q[7:0]};
            end
            form_far, form_call: begin
                dec.lit20      = {word1_q[11:0], word0_q[7:0]};
                dec.abs_target = {dec.lit20, 1'b0};
                dec.fast       = (form_q == form_call) && word0_q[POS_S_CAL];
            end
            form_rel11: dec.rel_disp = sext11(word0_q[10:0]);
            form_rel8:
                dec.rel_disp = sext11({{3{word0_q[7]}}, word0_q[7:0]});
            form_table: dec.step = step_e'(word0_q[1:0]);
            form_ret: dec.fast = word0_q[POS_S_RET];
            form_idx: begin
                dec.off_src = word0_q[6:0];
                dec.off_dst = word1_q[6:0];
            end
            default: dec.nop = 1'b1;
        endcase
    end

    assign eff_src = idx_base + {5'h00, dec.off_src};
    assign eff_dst = idx_base + {5'h00, dec.off_dst};

    // ----------------------------------------
    // Shadow copies
    // ----------------------------------------
    logic [7:0]  wacc_q;
    status_s     flags_q;
    logic [7:0]  sh_wacc;
    status_s     sh_flags;
    logic [3:0]  sh_bank;
    logic        fast_save;
    logic        fast_load;
    assign fast_save = call_strobe && full_q && dec.fast;
    assign fast_load = ret_strobe && full_q && dec.fast;

    fast_shadow_bank u_shadow (
        .core_clk (core_clk),
        .resetn   (resetn),
        .save     (fast_save),
        .wacc_d   (wacc_q),
        .flags_d  (flags_q),
        .bank_d   (bank_q),
        .wacc_q   (sh_wacc),
        .flags_q  (sh_flags),
        .bank_q   (sh_bank)
    );

    // ----------------------------------------
    // Accumulator, bank select, flags
    // ----------------------------------------
    logic wacc_load;
    assign wacc_load = result_valid && full_q && !dec.dest_file;
    assign file_we   = result_valid && full_q && dec.dest_file;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            wacc_q <= '0;
        else if (fast_load)
            wacc_q <= sh_wacc;
        else if (wacc_load)
            wacc_q <= result_data;
        else if (reg_wr && reg_addr == REG_WACC)
            wacc_q <= reg_wdata[7:0];
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            bank_q <= '0;
        else if (fast_load)
            bank_q <= sh_bank;
        else if (reg_wr && reg_addr == REG_BANK)
            bank_q <= reg_wdata[BANK_W-1:0];
    end

    // Hardware updates win over a software write in the same cycle
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            flags_q <= '0;
        else if (fast_load)
            flags_q <= sh_flags;
        else
            for (int i = 0; i < $bits(status_s); i++) begin
                if (flag_we[i])
                    flags_q[i] <= flag_in[i];
                else if (reg_wr && reg_addr == REG_FLAGS)
                    flags_q[i] <= reg_wdata[i];
            end
    end

    // ----------------------------------------
    // Table pointer and latch
    // ----------------------------------------
    logic [TPTR_W-1:0] tptr_q;
    logic [7:0]        tlat_q;
    logic              tbl_go;
    assign tbl_go   = tbl_strobe && full_q && form_q == form_table;
    assign tbl_addr = ptr_used(tptr_q, dec.step);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            tptr_q <= '0;
        else if (tbl_go)
            tptr_q <= ptr_next(tptr_q, dec.step);
        else if (reg_wr && reg_addr == REG_TPTR)
            tptr_q <= reg_wdata[TPTR_W-1:0];
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            tlat_q <= '0;
        else if (tbl_data_valid)
            tlat_q <= tbl_data;
        else if (reg_wr && reg_addr == REG_TLAT)
            tlat_q <= reg_wdata[7:0];
    end

    assign working_accumulator   = wacc_q;
    assign bank_select_reg       = bank_q;
    assign status_flags          = flags_q;
    assign program_table_pointer = tptr_q;
    assign table_read_latch      = tlat_q;

    // ----------------------------------------
    // Register read port
    // ----------------------------------------
    logic [31:0] rdata_q;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            rdata_q <= '0;
        else if (reg_rd)
            case (reg_addr)
                REG_BANK:  rdata_q <= {28'h0000000, bank_q};
                REG_WACC:  rdata_q <= {24'h000000, wacc_q};
                REG_FLAGS: rdata_q <= {27'h0000000, flags_q};
                REG_TPTR:  rdata_q <= {11'h000, tptr_q};
                REG_TLAT:  rdata_q <= {24'h000000, tlat_q};
                REG_IWORD: rdata_q <= {word1_q, word0_q};
                REG_DSTAT: rdata_q <= {14'h0000, full_q, state_q, form_q, dec.ram_addr};
                default:   rdata_q <= '0;
            endcase
        else
            rdata_q <= '0;
    end

    assign reg_rdata = rdata_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_access_region: assert property (@(posedge core_clk) disable iff (!resetn)
        full_q && form_q == form_byte && !word0_q[POS_A]
        |-> dec.ram_addr[11:8] == (word0_q[7] ? ACC_HI_BANK : ACC_LO_BANK))
        else $error("access region address wrong");
    a_banked_addr: assert property (@(posedge core_clk) disable iff (!resetn)
        full_q && form_q == form_bit && word0_q[POS_A]
        |-> dec.ram_addr == {bank_q, word0_q[7:0]})
        else $error("banked address wrong");
    a_dest_accum: assert property (@(posedge core_clk) disable iff (!resetn)
        wacc_load && !fast_load |=> wacc_q == $past(result_data))
        else $error("result not in accumulator");
    a_bit_mask: assert property (@(posedge core_clk) disable iff (!resetn)
        form_q == form_bit |-> $onehot(dec.bit_mask) && dec.bit_mask[dec.bit_index])
        else $error("bit mask wrong");
    a_move_pair: assert property (@(posedge core_clk) disable iff (!resetn)
        fetch_valid && state_q == st_second && pair_tag && form_q == form_move
        |=> full_q && dec.dst_addr == $past(fetch_word[11:0]))
        else $error("move destination wrong");
    a_step_post_inc: assert property (@(posedge core_clk) disable iff (!resetn)
        tbl_go && dec.step == step_post_inc
        |-> tbl_addr == tptr_q ##1 tptr_q == $past(tptr_q) + 21'h000001)
        else $error("post increment wrong");
    a_fast_restore: assert property (@(posedge core_clk) disable iff (!resetn)
        fast_load |=> wacc_q == $past(sh_wacc) && bank_q == $past(sh_bank))
        else $error("fast restore wrong");
    a_rel_sign: assert property (@(posedge core_clk) disable iff (!resetn)
        form_q == form_rel8 |-> dec.rel_disp[20:8] == {13{word0_q[7]}})
        else $error("displacement sign wrong");
    a_flag_update: assert property (@(posedge core_clk) disable iff (!resetn)
        flag_we.zero && !fast_load |=> flags_q.zero == $past(flag_in.zero))
        else $error("zero flag not updated");
    a_lone_nop: assert property (@(posedge core_clk) disable iff (!resetn)
        fetch_valid && state_q == st_first && lone_tag |=> full_q && dec.nop)
        else $error("lone second word not a nop");

    c_move_done: cover property (@(posedge core_clk) disable iff (!resetn) full_q && form_q == form_move);
    c_pre_inc: cover property (@(posedge core_clk) disable iff (!resetn) tbl_go && dec.step == step_pre_inc);
    c_fast_ret: cover property (@(posedge core_clk) disable iff (!resetn) fast_load);
    c_lone_word: cover property (@(posedge core_clk) disable iff (!resetn)
        fetch_valid && state_q == st_first && lone_tag);

endmodule : opcode_field_decoder

`default_nettype wire

/* fetch_model.sv */
/*
 * Fetch unit model: hands one classified word per call to the decoder.
 * Assumes a single core_clk domain and opdec_pkg compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module fetch_model
    import opdec_pkg::*;
(
    // Clock
    input  wire logic        core_clk,
    // Fetch side
    output logic             fetch_valid,
    output logic [15:0]      fetch_word,
    output opdec_pkg::form_e fetch_form
);
    initial begin
        fetch_valid = 1'b0;
        fetch_word  = 16'h0000;
        fetch_form  = form_none;
    end

    // Word is held for exactly the taking edge, then scrambled
    task automatic send(input logic [15:0] w, input form_e f);
        @(posedge core_clk);
        fetch_valid <= 1'b1;
        fetch_word  <= w;
        fetch_form  <= f;
        @(posedge core_clk);
        fetch_valid <= 1'b0;
        fetch_word  <= ~w;
    endtask : send
endmodule : fetch_model

`default_nettype wire

/* opcode_field_decoder_bench.sv */
/*
 * Self-checking bench of the opcode field decoder.
 * Assumes opdec_pkg and fetch_model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module opcode_field_decoder_bench;
    import opdec_pkg::*;
    logic core_clk = 0, resetn = 0, result_valid = 0, call_strobe = 0, ret_strobe = 0;
    logic tbl_strobe = 0, tbl_data_valid = 0, reg_wr = 0, reg_rd = 0;
    logic [7:0] result_data = 0, tbl_data = 0, reg_addr = 0, table_read_latch, working_accumulator;
    logic [11:0] idx_base = 0, eff_src, eff_dst;
    logic [31:0] reg_wdata = 0, reg_rdata;
    status_s flag_we = '0, flag_in = '0, status_flags;
    decode_s dec;
    logic dec_valid, await_second, file_we, fetch_valid;
    logic [15:0] fetch_word;
    form_e fetch_form;
    logic [20:0] tbl_addr, program_table_pointer, p, n;
    logic [3:0] bank_select_reg, bank;
    int error_cnt = 0, checks = 0, i, m;
    logic [31:0] lf = 68917, b, d, t;
    logic [15:0] w, v;
    logic [11:0] e, x;
    logic [7:0] acc = 8'h00;

    always #5 core_clk = ~core_clk;

    fetch_model fm (.core_clk, .fetch_valid, .fetch_word, .fetch_form);
    opcode_field_decoder dut (.core_clk, .resetn, .fetch_valid, .fetch_word, .fetch_form, .dec, .dec_valid,
        .await_second, .result_valid, .result_data, .file_we, .flag_we, .flag_in, .call_strobe, .ret_strobe,
        .idx_base, .eff_src, .eff_dst, .tbl_strobe, .tbl_data_valid, .tbl_data, .tbl_addr, .working_accumulator,
        .bank_select_reg, .status_flags, .program_table_pointer, .table_read_latch, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        lf = lf[0] ? (lf >> 1) ^ 32'h80200003 : lf >> 1;
        return lf;
    endfunction : rnd

    task automatic chk(string nm, logic [31:0] s, logic [31:0] ex);
        checks++;
        if (s !== ex) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", nm, ex, s);
        end
    endtask : chk

    task automatic close_out();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : close_out

    task automatic wr(logic [7:0] a, logic [31:0] dt);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= dt;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~dt;
    endtask : wr

    task automatic rd(logic [7:0] a, logic [31:0] ex, string nm);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(nm, reg_rdata, ex);
    endtask : rd

    task automatic send2(logic [15:0] a, logic [15:0] c, form_e f);
        fm.send(a, f);
        #1 chk("await", {await_second, dec_valid}, 2'b10);
        fm.send(c, form_none);
        #1 chk("paired", {await_second, dec_valid}, 2'b01);
    endtask : send2

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        close_out();
    end

    initial begin
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        rd(REG_WACC, 0, "wacc_rst");
        rd(8'hfc, 0, "unmapped");
        for (i = 0; i < 20; i++) begin
            w = rnd();
            w[15] = 1'b0;
            b = rnd();
            d = rnd();
            bank = b[3:0];
            wr(REG_BANK, {28'h0, bank});
            fm.send(w, form_byte);
            e = w[8] ? {bank, w[7:0]} : (w[7:0] < 8'h80 ? {4'h0, w[7:0]} : {4'hf, w[7:0]});
            #1 chk("ram_addr", dec.ram_addr, e);
            @(posedge core_clk);
            result_valid <= 1'b1;
            result_data <= d[7:0];
            #1 chk("file_we", file_we, w[9]);
            @(posedge core_clk);
            result_valid <= 1'b0;
            if (!w[9]) acc = d[7:0];
            #1 chk("wacc", working_accumulator, acc);
            fm.send(w, form_bit);
            #1 chk("bit", {dec.bit_index, dec.bit_mask}, {w[11:9], 8'h01 << w[11:9]});
            fm.send(w, form_lit8);
            #1 chk("lit8", dec.lit8, w[7:0]);
            fm.send(w, form_rel8);
            #1 chk("rel8", dec.rel_disp, {{13{w[7]}}, w[7:0]});
            fm.send(w, form_rel11);
            #1 chk("rel11", dec.rel_disp, {{10{w[10]}}, w[10:0]});
            v = rnd();
            v[15:12] = 4'hf;
            send2(w, v, form_move);
            chk("move", {dec.src_addr, dec.dst_addr}, {w[11:0], v[11:0]});
            send2(w, v, form_far);
            chk("lit20", dec.lit20, {v[11:0], w[7:0]});
            chk("abs", dec.abs_target, {v[11:0], w[7:0], 1'b0});
            send2(w, v, form_ptrld);
            chk("ptr", {dec.ptr_sel, dec.lit12}, {w[5:4], w[3:0], v[7:0]});
            send2(w, v, form_call);
            chk("fast", dec.fast, w[8]);
            @(posedge core_clk) idx_base <= b[27:16];
            x = b[27:16] + {5'h00, v[6:0]};
            e = b[27:16] + {5'h00, w[6:0]};
            send2(w, v, form_idx);
            chk("eff", eff_dst, x);
            chk("eff_src", eff_src, e);
        end
        send2(16'h0123, 16'h0456, form_move);
        chk("bad_pair", dec.form, form_none);
        fm.send(16'hf123, form_byte);
        #1 chk("nop", {dec.nop, dec.form}, {1'b1, form_none});
        for (m = 0; m < 4; m++) begin
            t = rnd();
            p = t[20:0];
            n = (m == 0) ? p : ((m == 2) ? p - 21'h1 : p + 21'h1);
            wr(REG_TPTR, {11'h0, p});
            fm.send({14'h0, m[1:0]}, form_table);
            #1 chk("taddr", tbl_addr, (m == 3) ? n : p);
            @(posedge core_clk);
            tbl_strobe <= 1'b1;
            tbl_data_valid <= 1'b1;
            tbl_data <= t[28:21];
            flag_we <= '1;
            flag_in <= t[4:0];
            @(posedge core_clk);
            tbl_strobe <= 1'b0;
            tbl_data_valid <= 1'b0;
            flag_we <= '0;
            #1 chk("tptr", program_table_pointer, n);
            chk("tlat", table_read_latch, t[28:21]);
            chk("flags", status_flags, t[4:0]);
        end
        send2(16'h0100, 16'hf000, form_call);
        @(posedge core_clk) call_strobe <= 1'b1;
        @(posedge core_clk) call_strobe <= 1'b0;
        wr(REG_WACC, {24'h0, ~acc});
        wr(REG_BANK, {28'h0, ~bank});
        wr(REG_FLAGS, {27'h0, ~t[4:0]});
        fm.send(16'h0001, form_ret);
        #1 chk("ret_fast", dec.fast, 1'b1);
        @(posedge core_clk) ret_strobe <= 1'b1;
        @(posedge core_clk) ret_strobe <= 1'b0;
        #1 chk("restore", {working_accumulator, bank_select_reg, status_flags}, {acc, bank, t[4:0]});
        rd(REG_BANK, {28'h0, bank}, "bank");
        rd(REG_WACC, {24'h0, acc}, "wacc");
        close_out();
    end
endmodule : opcode_field_decoder_bench

`default_nettype wire
